/* pkg/isrm_pkg.sv */
// Summary of operation
// - one byte per address, high byte lowest
// - start frequency 24 bits from 82h
// - step count uses bits 8..0 only
// - settling: 9-bit count, 2-bit multiplier code
// - multiplier code 11 waits four times count
// - leak limits keep low nibble only
// - index counter advances on increment command
// - index counter clears at start frequency
// - temperature is 14-bit two's complement value
// - increment adds step word to frequency
package isrm_pkg;
    localparam logic [7:0] ISRM_A_CTRL_HI   = 8'h80;
    localparam logic [7:0] ISRM_A_CTRL_LO   = 8'h81;
    localparam logic [7:0] ISRM_A_START_2   = 8'h82;
    localparam logic [7:0] ISRM_A_START_1   = 8'h83;
    localparam logic [7:0] ISRM_A_START_0   = 8'h84;
    localparam logic [7:0] ISRM_A_STEP_2    = 8'h85;
    localparam logic [7:0] ISRM_A_STEP_1    = 8'h86;
    localparam logic [7:0] ISRM_A_STEP_0    = 8'h87;
    localparam logic [7:0] ISRM_A_COUNT_HI  = 8'h88;
    localparam logic [7:0] ISRM_A_COUNT_LO  = 8'h89;
    localparam logic [7:0] ISRM_A_SETTLE_HI = 8'h8A;
    localparam logic [7:0] ISRM_A_SETTLE_LO = 8'h8B;
    localparam logic [7:0] ISRM_A_LEAK_A    = 8'h8C;
    localparam logic [7:0] ISRM_A_LEAK_B    = 8'h8D;
    localparam logic [7:0] ISRM_A_LEAK_C    = 8'h8E;
    localparam logic [7:0] ISRM_A_STATUS    = 8'h8F;
    localparam logic [7:0] ISRM_A_INDEX_HI  = 8'h90;
    localparam logic [7:0] ISRM_A_INDEX_LO  = 8'h91;
    localparam logic [7:0] ISRM_A_TEMP_HI   = 8'h92;
    localparam logic [7:0] ISRM_A_TEMP_LO   = 8'h93;

    localparam logic [15:0] ISRM_CTRL_RESET = 16'hA000;
    localparam int ISRM_CMD_MSB   = 15;
    localparam int ISRM_CMD_LSB   = 11;
    localparam int ISRM_CNT_W     = 9;
    localparam int ISRM_MULT_LSB  = 9;
    localparam int ISRM_LEAK_W    = 4;
    localparam int ISRM_TEMP_W    = 14;

    typedef enum logic [4:0] {
        ISRM_CMD_NOP    = 5'h00,
        ISRM_CMD_INIT   = 5'h01,
        ISRM_CMD_SWEEP  = 5'h02,
        ISRM_CMD_INCR   = 5'h03,
        ISRM_CMD_REPEAT = 5'h04
    } isrm_cmd_e;

    typedef enum logic [1:0] {
        ISRM_MULT_X1  = 2'b00,
        ISRM_MULT_RSV = 2'b01,
        ISRM_MULT_X2  = 2'b10,
        ISRM_MULT_X4  = 2'b11
    } isrm_mult_e;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } isrm_req_s;
endpackage

/* logic/isrm_point_index.sv */
module isrm_point_index
    import isrm_pkg::*;
#(
    parameter int WIDTH = 9
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // events
    input  wire logic             clear_evt,
    input  wire logic             step_evt,
    // count
    output logic [WIDTH-1:0]      index
);
    logic [WIDTH-1:0] index_r;
    logic [WIDTH-1:0] index_nxt;

    initial begin
        if (WIDTH < 1 || WIDTH > 16) $error("isrm_point_index: bad WIDTH");
    end

    always_comb begin
        index_nxt = index_r;
        if (clear_evt) begin
            index_nxt = '0;
        end else if (step_evt) begin
            index_nxt = index_r + WIDTH'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            index_r <= '0;
        end else begin
            index_r <= index_nxt;
        end
    end

    assign index = index_r;

    property p_index_step;
        @(posedge ref_clk) disable iff (reset)
        (step_evt && !clear_evt) |=> index_r == $past(index_r) + WIDTH'(1);
    endproperty
    a_index_step: assert property (p_index_step) else $error("index did not advance");

    property p_index_clear;
        @(posedge ref_clk) disable iff (reset)
        clear_evt |=> index_r == '0;
    endproperty
    a_index_clear: assert property (p_index_clear) else $error("index not cleared");

    property p_index_hold;
        @(posedge ref_clk) disable iff (reset)
        (!clear_evt && !step_evt) |=> $stable(index_r);
    endproperty
    a_index_hold: assert property (p_index_hold) else $error("index moved unprompted");
endmodule

/* logic/isrm_register_map.sv */
module isrm_register_map
    import isrm_pkg::*;
#(
    parameter int FREQ_W = 24
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // byte access from the serial interface
    input  wire isrm_req_s            req,
    output logic [7:0]                rdata,
    // sweep engine events
    input  wire logic                 point_done,
    input  wire logic [ISRM_TEMP_W-1:0] temp_code,
    input  wire logic                 temp_valid,
    input  wire logic [7:0]           status_set,
    // decoded configuration
    output logic [FREQ_W-1:0]         cur_freq,
    output logic [ISRM_CNT_W-1:0]     step_total,
    output logic [ISRM_CNT_W+1:0]     settle_wait,
    output logic [3*ISRM_LEAK_W-1:0]  leak_limits,
    output logic [15:0]               ctrl_word,
    output logic [ISRM_CNT_W-1:0]     point_index
);
    logic [15:0]              ctrl_r, ctrl_nxt;
    logic [23:0]              start_r, start_nxt;
    logic [23:0]              step_r, step_nxt;
    logic [15:0]              count_r, count_nxt;
    logic [15:0]              settle_r, settle_nxt;
    logic [ISRM_LEAK_W-1:0]   leak_r [3];
    logic [ISRM_LEAK_W-1:0]   leak_nxt [3];
    logic [7:0]               status_r, status_nxt;
    logic [ISRM_TEMP_W-1:0]   temp_r, temp_nxt;
    logic [FREQ_W-1:0]        freq_r, freq_nxt;
    logic [7:0]               rdata_r, rdata_nxt;
    logic                     cmd_wr;
    logic [4:0]               cmd_code;
    logic                     do_init;
    logic                     do_incr;
    logic [ISRM_CNT_W-1:0]    index_q;
    logic [ISRM_CNT_W-1:0]    settle_cnt;
    isrm_mult_e               settle_mult;

    initial begin
        if (FREQ_W != 24) $error("isrm_register_map: FREQ_W must be 24");
    end

    // a command takes effect when the high control byte is written
    assign cmd_wr   = req.wr_en && req.addr == ISRM_A_CTRL_HI;
    assign cmd_code = req.wdata[ISRM_CMD_MSB-8:ISRM_CMD_LSB-8];
    assign do_init  = cmd_wr && (cmd_code == ISRM_CMD_INIT || cmd_code == ISRM_CMD_SWEEP);
    assign do_incr  = cmd_wr && cmd_code == ISRM_CMD_INCR;

    always_comb begin
        ctrl_nxt   = ctrl_r;
        start_nxt  = start_r;
        step_nxt   = step_r;
        count_nxt  = count_r;
        settle_nxt = settle_r;
        leak_nxt   = leak_r;
        status_nxt = status_r | status_set; // set wins over a software write
        temp_nxt   = temp_valid ? temp_code : temp_r;
        freq_nxt   = freq_r;
        if (req.wr_en) begin
            if (req.addr == ISRM_A_CTRL_HI) begin
                ctrl_nxt[15:8] = req.wdata;
            end else if (req.addr == ISRM_A_CTRL_LO) begin
                ctrl_nxt[7:0] = req.wdata;
            end else if (req.addr == ISRM_A_START_2) begin
                start_nxt[23:16] = req.wdata;
            end else if (req.addr == ISRM_A_START_1) begin
                start_nxt[15:8] = req.wdata;
            end else if (req.addr == ISRM_A_START_0) begin
                start_nxt[7:0] = req.wdata;
            end else if (req.addr == ISRM_A_STEP_2) begin
                step_nxt[23:16] = req.wdata;
            end else if (req.addr == ISRM_A_STEP_1) begin
                step_nxt[15:8] = req.wdata;
            end else if (req.addr == ISRM_A_STEP_0) begin
                step_nxt[7:0] = req.wdata;
            end else if (req.addr == ISRM_A_COUNT_HI) begin
                count_nxt[15:8] = req.wdata;
            end else if (req.addr == ISRM_A_COUNT_LO) begin
                count_nxt[7:0] = req.wdata;
            end else if (req.addr == ISRM_A_SETTLE_HI) begin
                settle_nxt[15:8] = req.wdata;
            end else if (req.addr == ISRM_A_SETTLE_LO) begin
                settle_nxt[7:0] = req.wdata;
            end else if (req.addr == ISRM_A_LEAK_A) begin
                leak_nxt[0] = req.wdata[ISRM_LEAK_W-1:0];
            end else if (req.addr == ISRM_A_LEAK_B) begin
                leak_nxt[1] = req.wdata[ISRM_LEAK_W-1:0];
            end else if (req.addr == ISRM_A_LEAK_C) begin
                leak_nxt[2] = req.wdata[ISRM_LEAK_W-1:0];
            end else if (req.addr == ISRM_A_STATUS) begin
                status_nxt = req.wdata | status_set;
            end
        end
        if (do_init) begin
            freq_nxt = start_nxt;
        end else if (do_incr) begin
            freq_nxt = freq_r + step_r;
        end
    end

    // read data is registered: byte shows the cycle after rd_en
    always_comb begin
        rdata_nxt = rdata_r;
        if (req.rd_en) begin
            if (req.addr == ISRM_A_CTRL_HI) begin
                rdata_nxt = ctrl_r[15:8];
            end else if (req.addr == ISRM_A_CTRL_LO) begin
                rdata_nxt = ctrl_r[7:0];
            end else if (req.addr == ISRM_A_START_2) begin
                rdata_nxt = start_r[23:16];
            end else if (req.addr == ISRM_A_START_1) begin
                rdata_nxt = start_r[15:8];
            end else if (req.addr == ISRM_A_START_0) begin
                rdata_nxt = start_r[7:0];
            end else if (req.addr == ISRM_A_STEP_2) begin
                rdata_nxt = step_r[23:16];
            end else if (req.addr == ISRM_A_STEP_1) begin
                rdata_nxt = step_r[15:8];
            end else if (req.addr == ISRM_A_STEP_0) begin
                rdata_nxt = step_r[7:0];
            end else if (req.addr == ISRM_A_COUNT_HI) begin
                rdata_nxt = count_r[15:8];
            end else if (req.addr == ISRM_A_COUNT_LO) begin
                rdata_nxt = count_r[7:0];
            end else if (req.addr == ISRM_A_SETTLE_HI) begin
                rdata_nxt = settle_r[15:8];
            end else if (req.addr == ISRM_A_SETTLE_LO) begin
                rdata_nxt = settle_r[7:0];
            end else if (req.addr == ISRM_A_LEAK_A) begin
                rdata_nxt = {4'h0, leak_r[0]};
            end else if (req.addr == ISRM_A_LEAK_B) begin
                rdata_nxt = {4'h0, leak_r[1]};
            end else if (req.addr == ISRM_A_LEAK_C) begin
                rdata_nxt = {4'h0, leak_r[2]};
            end else if (req.addr == ISRM_A_STATUS) begin
                rdata_nxt = status_r;
            end else if (req.addr == ISRM_A_INDEX_HI) begin
                rdata_nxt = 8'({7'h00, index_q[ISRM_CNT_W-1]});
            end else if (req.addr == ISRM_A_INDEX_LO) begin
                rdata_nxt = index_q[7:0];
            end else if (req.addr == ISRM_A_TEMP_HI) begin
                rdata_nxt = {2'b00, temp_r[13:8]};
            end else if (req.addr == ISRM_A_TEMP_LO) begin
                rdata_nxt = temp_r[7:0];
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_r   <= ISRM_CTRL_RESET;
            start_r  <= '0;
            step_r   <= '0;
            count_r  <= '0;
            settle_r <= '0;
            leak_r   <= '{default: '0};
            status_r <= '0;
            temp_r   <= '0;
            freq_r   <= '0;
            rdata_r  <= '0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            start_r  <= start_nxt;
            step_r   <= step_nxt;
            count_r  <= count_nxt;
            settle_r <= settle_nxt;
            leak_r   <= leak_nxt;
            status_r <= status_nxt;
            temp_r   <= temp_nxt;
            freq_r   <= freq_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    isrm_point_index #(
        .WIDTH (ISRM_CNT_W)
    ) u_index (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .clear_evt (do_init),
        .step_evt  (do_incr),
        .index     (index_q)
    );

    assign settle_cnt  = settle_r[ISRM_CNT_W-1:0];
    assign settle_mult = isrm_mult_e'(settle_r[ISRM_MULT_LSB+1:ISRM_MULT_LSB]);
    // reserved code falls back to unscaled; host must not use it
    always_comb begin
        case (settle_mult)
            ISRM_MULT_X4: settle_wait = {settle_cnt, 2'b00};
            ISRM_MULT_X2: settle_wait = {1'b0, settle_cnt, 1'b0};
            default:      settle_wait = {2'b00, settle_cnt};
        endcase
    end

    assign step_total  = count_r[ISRM_CNT_W-1:0];
    assign leak_limits = {leak_r[2], leak_r[1], leak_r[0]};
    assign cur_freq    = freq_r;
    assign ctrl_word   = ctrl_r;
    assign point_index = index_q;
    assign rdata       = rdata_r;

    property p_init_freq;
        @(posedge ref_clk) disable iff (reset)
        do_init |=> cur_freq == start_r;
    endproperty
    a_init_freq: assert property (p_init_freq) else $error("start frequency not loaded");

    property p_incr_freq;
        @(posedge ref_clk) disable iff (reset)
        do_incr |=> cur_freq == $past(freq_r) + $past(step_r);
    endproperty
    a_incr_freq: assert property (p_incr_freq) else $error("frequency not stepped");

    property p_start_byte;
        @(posedge ref_clk) disable iff (reset)
        (req.wr_en && req.addr == ISRM_A_START_2) |=> start_r[23:16] == $past(req.wdata);
    endproperty
    a_start_byte: assert property (p_start_byte) else $error("start high byte misplaced");

    property p_leak_nibble;
        @(posedge ref_clk) disable iff (reset)
        (req.rd_en && req.addr == ISRM_A_LEAK_A) |=> rdata == {4'h0, $past(leak_r[0])};
    endproperty
    a_leak_nibble: assert property (p_leak_nibble) else $error("leak limit upper bits set");

    property p_settle_x4;
        @(posedge ref_clk) disable iff (reset)
        settle_mult == ISRM_MULT_X4 |-> settle_wait == 11'(settle_cnt) * 11'd4;
    endproperty
    a_settle_x4: assert property (p_settle_x4) else $error("x4 wait wrong");

    property p_settle_x1;
        @(posedge ref_clk) disable iff (reset)
        settle_mult == ISRM_MULT_X1 |-> settle_wait == 11'(settle_cnt);
    endproperty
    a_settle_x1: assert property (p_settle_x1) else $error("x1 wait wrong");

    property p_count_mask;
        @(posedge ref_clk) disable iff (reset)
        (req.wr_en && req.addr == ISRM_A_COUNT_HI) |=> step_total[ISRM_CNT_W-1] == $past(req.wdata[0]);
    endproperty
    a_count_mask: assert property (p_count_mask) else $error("step count mask wrong");

    property p_temp_read;
        @(posedge ref_clk) disable iff (reset)
        (req.rd_en && req.addr == ISRM_A_TEMP_HI) |=> rdata == {2'b00, $past(temp_r[13:8])};
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temperature high byte wrong");

    property p_ctrl_byte;
        @(posedge ref_clk) disable iff (reset)
        (req.wr_en && req.addr == ISRM_A_CTRL_LO) |=> ctrl_r[7:0] == $past(req.wdata);
    endproperty
    a_ctrl_byte: assert property (p_ctrl_byte) else $error("control low byte misplaced");

    c_init:  cover property (@(posedge ref_clk) disable iff (reset) do_init);
    c_incr:  cover property (@(posedge ref_clk) disable iff (reset) do_incr ##2 do_incr);
    c_x4:    cover property (@(posedge ref_clk) disable iff (reset) settle_mult == ISRM_MULT_X4);
    c_tread: cover property (@(posedge ref_clk) disable iff (reset) req.rd_en && req.addr == ISRM_A_TEMP_LO);
endmodule

/* testbench/isrm_host_model.sv */
module isrm_host_model
    import isrm_pkg::*;
(
    // clock
    input  wire logic       ref_clk,
    // byte access towards the register map
    output isrm_req_s       req,
    input  wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial req = '0;

    // released lines show inverted values so that a stale address or byte is never mistaken for a live one
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        #2;
        req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
        @(posedge ref_clk);
        #2;
    endtask

    // data is taken just after the edge that accepted the read, where it is registered
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        #2;
        d = rdata;
        req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 8'hFF};
        @(posedge ref_clk);
        #2;
    endtask
endmodule

/* testbench/isrm_register_map_test.sv */
module isrm_register_map_test
    import isrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                     ref_clk;
    logic                     reset;
    isrm_req_s                req;
    logic [7:0]               rdata;
    logic                     point_done;
    logic [ISRM_TEMP_W-1:0]   temp_code;
    logic                     temp_valid;
    logic [7:0]               status_set;
    logic [23:0]              cur_freq;
    logic [ISRM_CNT_W-1:0]    step_total;
    logic [ISRM_CNT_W+1:0]    settle_wait;
    logic [3*ISRM_LEAK_W-1:0] leak_limits;
    logic [15:0]              ctrl_word;
    logic [ISRM_CNT_W-1:0]    point_index;
    int                       n_fail;
    int                       checks;

    localparam logic [23:0] START_F = 24'h123456;
    localparam logic [23:0] STEP_F  = 24'h001001;

    isrm_register_map i_isrm_register_map (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .req         (req),
        .rdata       (rdata),
        .point_done  (point_done),
        .temp_code   (temp_code),
        .temp_valid  (temp_valid),
        .status_set  (status_set),
        .cur_freq    (cur_freq),
        .step_total  (step_total),
        .settle_wait (settle_wait),
        .leak_limits (leak_limits),
        .ctrl_word   (ctrl_word),
        .point_index (point_index)
    );

    isrm_host_model i_isrm_host_model (
        .ref_clk (ref_clk),
        .req     (req),
        .rdata   (rdata)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_isrm_host_model.write_byte(a, d);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        i_isrm_host_model.read_byte(a, d);
        check_byte(d, exp, what);
    endtask

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        int          i;
        int          mult[4];
        logic [13:0] temps[2];
        mult = '{1, 1, 2, 4};
        temps = '{14'h3B00, 14'h0320};
        reset = 1'b1;
        point_done = 1'b0;
        temp_code = '0;
        temp_valid = 1'b0;
        status_set = 8'h00;
        repeat (8) @(posedge ref_clk);
        #2;
        reset = 1'b0;
        check_word({8'h00, ctrl_word}, {8'h00, ISRM_CTRL_RESET}, "ctrl reset");
        rd_check(ISRM_A_CTRL_HI, ISRM_CTRL_RESET[15:8], "ctrl hi reset");
        rd_check(ISRM_A_CTRL_LO, ISRM_CTRL_RESET[7:0], "ctrl lo reset");
        // start and step words, high byte at the lowest address
        for (i = 0; i < 3; i++) begin
            wr(ISRM_A_START_2 + 8'(i), START_F[23-8*i -: 8]);
            wr(ISRM_A_STEP_2 + 8'(i), STEP_F[23-8*i -: 8]);
        end
        for (i = 0; i < 3; i++) begin
            rd_check(ISRM_A_START_2 + 8'(i), START_F[23-8*i -: 8], "start byte");
        end
        wr(ISRM_A_COUNT_HI, 8'hFF);
        wr(ISRM_A_COUNT_LO, 8'h2A);
        check_word(24'(step_total), 24'h00012A, "step count");
        // every multiplier code, with the don't-care bits set
        for (i = 0; i < 4; i++) begin
            wr(ISRM_A_SETTLE_HI, {5'b11111, 2'(i), 1'b1});
            wr(ISRM_A_SETTLE_LO, 8'h03);
            check_word(24'(settle_wait), 24'(259 * mult[i]), "settle wait");
        end
        wr(ISRM_A_LEAK_A, 8'hFF);
        wr(ISRM_A_LEAK_B, 8'hA5);
        wr(ISRM_A_LEAK_C, 8'h3C);
        check_word(24'(leak_limits), 24'h000C5F, "leak limits");
        rd_check(ISRM_A_LEAK_B, 8'h05, "leak b read");
        // sweep commands through the control high byte
        wr(ISRM_A_CTRL_HI, {ISRM_CMD_INIT, 3'b000});
        check_word(cur_freq, START_F, "init freq");
        check_word(24'(point_index), 24'h0, "init index");
        wr(ISRM_A_CTRL_HI, {ISRM_CMD_INCR, 3'b000});
        wr(ISRM_A_CTRL_HI, {ISRM_CMD_INCR, 3'b000});
        check_word(cur_freq, START_F + STEP_F + STEP_F, "incr freq");
        rd_check(ISRM_A_INDEX_HI, 8'h00, "index hi");
        rd_check(ISRM_A_INDEX_LO, 8'h02, "index lo");
        wr(ISRM_A_CTRL_HI, {ISRM_CMD_SWEEP, 3'b000});
        check_word(cur_freq, START_F, "sweep freq");
        check_word(24'(point_index), 24'h0, "sweep index");
        // read-only and unmapped places
        wr(ISRM_A_INDEX_LO, 8'hFF);
        rd_check(ISRM_A_INDEX_LO, 8'h00, "index read only");
        rd_check(8'hA0, 8'h00, "unmapped read");
        // a negative and a positive reading
        for (i = 0; i < 2; i++) begin
            temp_code = temps[i];
            temp_valid = 1'b1;
            @(posedge ref_clk);
            #2;
            temp_valid = 1'b0;
            rd_check(ISRM_A_TEMP_HI, {2'b00, temps[i][13:8]}, "temp hi");
            rd_check(ISRM_A_TEMP_LO, temps[i][7:0], "temp lo");
        end
        wr(ISRM_A_STATUS, 8'h05);
        status_set = 8'h40;
        @(posedge ref_clk);
        #2;
        status_set = 8'h00;
        rd_check(ISRM_A_STATUS, 8'h45, "status sticky");
        // leave the index and frequency off their reset values so the reset check can trip
        wr(ISRM_A_CTRL_HI, {ISRM_CMD_INCR, 3'b000});
        check_word(24'(point_index), 24'h000001, "index before reset");
        check_word(cur_freq, START_F + STEP_F, "freq before reset");
        // a second reset in mid-run
        reset = 1'b1;
        @(posedge ref_clk);
        #2;
        reset = 1'b0;
        check_word({8'h00, ctrl_word}, {8'h00, ISRM_CTRL_RESET}, "ctrl second reset");
        check_word(cur_freq, 24'h000000, "freq second reset");
        check_word(24'(point_index), 24'h0, "index second reset");
        finish_test();
    end
endmodule
